/* File: ipm_pkg.sv */
// constants for the interrupt flag/mask and power mode controller
package ipm_pkg;
    // ------------------------------------------------------------
    // register locations (nibble addresses)
    // ------------------------------------------------------------
    localparam logic [9:0] ADDR_WORD0  = 10'h000;
    localparam logic [9:0] ADDR_WORD1  = 10'h001;
    localparam logic [9:0] ADDR_WORD2  = 10'h002;
    localparam logic [9:0] ADDR_WORD3  = 10'h003;
    localparam logic [9:0] ADDR_PMODEA = 10'h004;
    localparam logic [9:0] ADDR_EDGE   = 10'h010;
    localparam logic [9:0] ADDR_SERIAL = 10'h023;
    // ------------------------------------------------------------
    // cause indices: priority order, 0 highest
    // ------------------------------------------------------------
    localparam int NUM_SRC = 8;
    localparam int SRC_EXT0 = 0;
    localparam int SRC_EXT1 = 1;
    localparam int SRC_TMRA = 2;
    localparam int SRC_TMRB = 3;
    localparam int SRC_TMRC = 4;
    localparam int SRC_ZC   = 5;
    localparam int SRC_ADC  = 6;
    localparam int SRC_SER  = 7;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int BIT_GIE = 0;
    localparam int EDGE_EXT1_LO = 0;
    localparam int EDGE_ZC_LO   = 2;
    localparam logic [3:0] MASK_RESET   = 4'hf;
    localparam logic [3:0] NIBBLE_RESET = 4'h0;
    // vector step per cause: vector = VEC_STEP * (index+1), ad/serial share
    localparam logic [13:0] VEC_STEP = 14'h0002;
    // ------------------------------------------------------------
    // timing: stabilisation time and frame length in clock cycles
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int STAB_US = 8000;
    localparam int STAB_CYCLES = STAB_US * CLK_MHZ;
    localparam int FRAME_US = 7812;
    localparam int FRAME_CYCLES = FRAME_US * CLK_MHZ;

    typedef enum logic [2:0] {
        MODE_ACTIVE,
        MODE_STANDBY,
        MODE_STOP,
        MODE_WATCH,
        MODE_WAKE,
        MODE_SUBACTIVE
    } ipm_mode_t;
endpackage : ipm_pkg

/* File: ipm_irq_power_ctrl.sv */
// interrupt request flags, masks, priority and low-power mode sequencing
`timescale 1ns/1ps

// How it works
// - ext0 flag (0x000 b2) sets on each falling edge of ext_irq0_n.
// - ext1 flag (0x001 b0) sets on the edge chosen by edge-select 0x010.
// - mask bit 1 blocks its cause, 0 passes it; positions per map.
// - timer A overflow sets flag 0x001 bit 2.
// - timer B overflow sets flag 0x002 bit 0.
// - timer C overflow sets flag 0x002 bit 2.
// - zero crossing sets flag 0x003 bit 0, edge chosen by edge-select.
// - A/D completion sets flag 0x003 bit 2.
// - eighth serial clock or counter reset abort sets flag 0x023 bit 2.
// - active mode runs cpu and peripherals from main oscillator.
// - standby stops only cpu clock; peripherals, interrupts run, state kept.
// - pending request ends standby; vectors only if global enable set.
// - stop with watch-select 0 halts oscillator, resets peripherals, floats pins.
// - stop mode leaves only through reset.
// - watch entered by stop with watch-select 1, or stop/standby in subactive.
// - timer A or ext0 request ends watch; low-speed select picks target.
// - watch-to-active waits stabilisation time, ext0 without timer A adds one frame more.
// - subactive runs cpu on subclock, main oscillator off, no A/D.
// - watch keeps timer A and LCD; others stop; serial raises no request.
// - interrupt taken when flag 1, mask 0, global enable 1; fixed priority.
// - interrupt entry clears global enable; return instruction sets it.
// - software only clears flags; hardware events alone set them.
// - stop or standby with enable 0 and unmasked request acts as no-op.
module ipm_irq_power_ctrl
    import ipm_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // cpu nibble access
    input  wire logic [9:0]  regAddr,
    input  wire logic        regWrite,
    input  wire logic [3:0]  regWdata,
    output logic      [3:0]  regRdata,
    output logic             regHit,
    // cpu instruction strobes
    input  wire logic        standbyInstr,
    input  wire logic        stopInstr,
    input  wire logic        irqEntry,
    input  wire logic        returnFromIrqInstr,
    input  wire logic        watchSelectBit,
    input  wire logic        lowSpeedSelect,
    // event sources
    input  wire logic        extIrq0N,
    input  wire logic        extIrq1,
    input  wire logic        zeroCrossIn,
    input  wire logic        tmrAOverflow,
    input  wire logic        tmrBOverflow,
    input  wire logic        tmrCOverflow,
    input  wire logic        adcDone,
    input  wire logic        serialEighthClk,
    input  wire logic        serialCounterReset,
    input  wire logic        frameStrobe,
    // request to cpu
    output logic             irqRequest,
    output logic      [13:0] irqVector,
    output logic             instrNop,
    // clock and power controls
    output logic             cpuClockEn,
    output logic             mainOscEn,
    output logic             subClockCpu,
    output logic             periphRun,
    output logic             slowPeriphRun,
    output logic             adcRun,
    output logic             serialIrqEn,
    output logic             periphResetReq,
    output logic             pinsFloat,
    output logic      [3:0]  portModeRegA,
    output logic      [3:0]  irqEdgeSelectReg,
    output logic      [2:0]  modeState
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0] flag_q, flag_d;
    logic [NUM_SRC-1:0] mask_q, mask_d;
    logic               gie_q, gie_d;
    logic [3:0]         pmodeA_q, pmodeA_d;
    logic [3:0]         edge_q, edge_d;
    logic               ext0Prev_q, ext1Prev_q, zcPrev_q;
    ipm_mode_t          mode_q, mode_d;
    logic [31:0]        wait_q, wait_d;
    logic               toSub_q, toSub_d;
    logic [NUM_SRC-1:0] event_s, clear_s;
    logic [NUM_SRC-1:0] pend;
    logic               anyPend, wakeWatch;

    // ------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------
    logic ext1Rise, ext1Fall, zcRise, zcFall, ext1Ev, zcEv, inWatch;
    always_comb
    begin
        inWatch  = (mode_q == MODE_WATCH) || (mode_q == MODE_WAKE);
        ext1Rise = extIrq1 & ~ext1Prev_q;
        ext1Fall = ~extIrq1 & ext1Prev_q;
        zcRise   = zeroCrossIn & ~zcPrev_q;
        zcFall   = ~zeroCrossIn & zcPrev_q;
        // edge select: 00 fall, 01 rise, 1x both
        ext1Ev = edge_q[EDGE_EXT1_LO+1] ? (ext1Rise | ext1Fall)
               : (edge_q[EDGE_EXT1_LO] ? ext1Rise : ext1Fall);
        zcEv   = edge_q[EDGE_ZC_LO+1] ? (zcRise | zcFall)
               : (edge_q[EDGE_ZC_LO] ? zcRise : zcFall);
        event_s = '0;
        event_s[SRC_EXT0] = ~extIrq0N & ext0Prev_q;
        event_s[SRC_EXT1] = ext1Ev & ~inWatch;
        event_s[SRC_TMRA] = tmrAOverflow;
        event_s[SRC_TMRB] = tmrBOverflow & ~inWatch;
        event_s[SRC_TMRC] = tmrCOverflow & ~inWatch;
        event_s[SRC_ZC]   = zcEv & ~inWatch;
        event_s[SRC_ADC]  = adcDone & adcRun;
        event_s[SRC_SER]  = (serialEighthClk | serialCounterReset) & ~inWatch;
    end

    // ------------------------------------------------------------
    // register access, flags and masks
    // ------------------------------------------------------------
    logic [3:0] wr;
    always_comb
    begin
        wr = regWdata;
        clear_s = '0;
        mask_d  = mask_q;
        gie_d   = gie_q;
        pmodeA_d = pmodeA_q;
        edge_d   = edge_q;
        if (regWrite)
        begin
            case (regAddr)
                ADDR_WORD0:
                begin
                    gie_d = wr[BIT_GIE];
                    clear_s[SRC_EXT0] = ~wr[2];
                    mask_d[SRC_EXT0] = wr[3];
                end
                ADDR_WORD1:
                begin
                    clear_s[SRC_EXT1] = ~wr[0];
                    mask_d[SRC_EXT1] = wr[1];
                    clear_s[SRC_TMRA] = ~wr[2];
                    mask_d[SRC_TMRA] = wr[3];
                end
                ADDR_WORD2:
                begin
                    clear_s[SRC_TMRB] = ~wr[0];
                    mask_d[SRC_TMRB] = wr[1];
                    clear_s[SRC_TMRC] = ~wr[2];
                    mask_d[SRC_TMRC] = wr[3];
                end
                ADDR_WORD3:
                begin
                    clear_s[SRC_ZC] = ~wr[0];
                    mask_d[SRC_ZC] = wr[1];
                    clear_s[SRC_ADC] = ~wr[2];
                    mask_d[SRC_ADC] = wr[3];
                end
                ADDR_SERIAL:
                begin
                    clear_s[SRC_SER] = ~wr[2];
                    mask_d[SRC_SER] = wr[3];
                end
                ADDR_PMODEA: pmodeA_d = wr;
                ADDR_EDGE:   edge_d = wr;
                default: ;
            endcase
        end
        if (irqEntry)
            gie_d = 1'b0;
        else if (returnFromIrqInstr)
            gie_d = 1'b1;
        // set wins over clear; software can never set
        flag_d = (flag_q & ~clear_s) | event_s;
        if (mode_q == MODE_STOP)
            flag_d = '0;
    end

    always_comb
    begin
        regHit = 1'b1;
        case (regAddr)
            ADDR_WORD0:  regRdata = {mask_q[SRC_EXT0], flag_q[SRC_EXT0], 1'b0, gie_q};
            ADDR_WORD1:  regRdata = {mask_q[SRC_TMRA], flag_q[SRC_TMRA],
                                     mask_q[SRC_EXT1], flag_q[SRC_EXT1]};
            ADDR_WORD2:  regRdata = {mask_q[SRC_TMRC], flag_q[SRC_TMRC],
                                     mask_q[SRC_TMRB], flag_q[SRC_TMRB]};
            ADDR_WORD3:  regRdata = {mask_q[SRC_ADC], flag_q[SRC_ADC],
                                     mask_q[SRC_ZC], flag_q[SRC_ZC]};
            ADDR_SERIAL: regRdata = {mask_q[SRC_SER], flag_q[SRC_SER], 2'b00};
            ADDR_PMODEA: regRdata = pmodeA_q;
            ADDR_EDGE:   regRdata = edge_q;
            default:
            begin
                regRdata = 4'h0;
                regHit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // priority and request
    // ------------------------------------------------------------
    always_comb
    begin
        pend = flag_q & ~mask_q;
        anyPend = |pend;
        irqVector = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (pend[i])
                irqVector = VEC_STEP * 14'((i == SRC_SER ? SRC_ADC : i) + 1);
        end
        irqRequest = anyPend & gie_q & (mode_q == MODE_ACTIVE
                                        || mode_q == MODE_SUBACTIVE);
        instrNop = (stopInstr | standbyInstr) & ~gie_q & anyPend;
        wakeWatch = pend[SRC_TMRA] | pend[SRC_EXT0];
    end

    // ------------------------------------------------------------
    // power mode sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        mode_d  = mode_q;
        wait_d  = wait_q;
        toSub_d = toSub_q;
        case (mode_q)
            MODE_ACTIVE:
            begin
                if (!instrNop && stopInstr)
                    mode_d = watchSelectBit ? MODE_WATCH : MODE_STOP;
                else if (!instrNop && standbyInstr)
                    mode_d = MODE_STANDBY;
            end
            MODE_STANDBY:
                if (anyPend)
                    mode_d = MODE_ACTIVE;
            MODE_STOP:
                mode_d = MODE_STOP;
            MODE_WATCH:
            begin
                if (wakeWatch)
                begin
                    toSub_d = lowSpeedSelect;
                    // ext0 adds one frame of sampling latency
                    wait_d = pend[SRC_EXT0] && !pend[SRC_TMRA]
                           ? 32'(STAB_CYCLES + FRAME_CYCLES) : 32'(STAB_CYCLES);
                    mode_d = lowSpeedSelect ? MODE_SUBACTIVE : MODE_WAKE;
                end
            end
            MODE_WAKE:
            begin
                if (wait_q <= 32'd1)
                    mode_d = MODE_ACTIVE;
                else
                    wait_d = wait_q - 32'd1;
            end
            MODE_SUBACTIVE:
                if (!instrNop && (stopInstr || standbyInstr))
                    mode_d = MODE_WATCH;
            default: mode_d = MODE_ACTIVE;
        endcase
    end

    always_comb
    begin
        cpuClockEn     = (mode_q == MODE_ACTIVE) || (mode_q == MODE_SUBACTIVE);
        mainOscEn      = (mode_q == MODE_ACTIVE) || (mode_q == MODE_STANDBY)
                         || (mode_q == MODE_WAKE);
        subClockCpu    = (mode_q == MODE_SUBACTIVE);
        periphRun      = (mode_q == MODE_ACTIVE) || (mode_q == MODE_STANDBY)
                         || (mode_q == MODE_SUBACTIVE);
        slowPeriphRun  = (mode_q != MODE_STOP);
        adcRun         = (mode_q == MODE_ACTIVE) || (mode_q == MODE_STANDBY);
        serialIrqEn    = ~inWatch;
        periphResetReq = (mode_q == MODE_STOP);
        pinsFloat      = (mode_q == MODE_STOP);
        modeState      = mode_q;
        portModeRegA   = pmodeA_q;
        irqEdgeSelectReg = edge_q;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            flag_q     <= '0;
            mask_q     <= {NUM_SRC{1'b1}};
            gie_q      <= 1'b0;
            pmodeA_q   <= NIBBLE_RESET;
            edge_q     <= NIBBLE_RESET;
            ext0Prev_q <= 1'b1;
            ext1Prev_q <= 1'b0;
            zcPrev_q   <= 1'b0;
            mode_q     <= MODE_ACTIVE;
            wait_q     <= '0;
            toSub_q    <= 1'b0;
        end
        else
        begin
            flag_q     <= flag_d;
            mask_q     <= mask_d;
            gie_q      <= gie_d;
            pmodeA_q   <= pmodeA_d;
            edge_q     <= edge_d;
            ext0Prev_q <= extIrq0N;
            ext1Prev_q <= extIrq1;
            zcPrev_q   <= zeroCrossIn;
            mode_q     <= mode_d;
            wait_q     <= wait_d;
            toSub_q    <= toSub_d;
        end
    end
endmodule : ipm_irq_power_ctrl

/* File: ipm_chk.sv */
// assertion checker for the interrupt and power mode controller
`timescale 1ns/1ps
module ipm_chk
(
    // clock and reset
    input wire logic       clock,
    input wire logic       resetn,
    // cpu side
    input wire logic       stopInstr,
    input wire logic       standbyInstr,
    input wire logic       irqEntry,
    input wire logic       watchSelectBit,
    input wire logic       instrNop,
    input wire logic       irqRequest,
    // power controls
    input wire logic       cpuClockEn,
    input wire logic       mainOscEn,
    input wire logic       subClockCpu,
    input wire logic       periphRun,
    input wire logic       pinsFloat,
    input wire logic [2:0] modeState
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    // an accepted stop instruction in active mode
    sequence sStopTaken;
        modeState == 3'h0 && stopInstr && !standbyInstr && !instrNop;
    endsequence

    chk_stop_entry: assert property (sStopTaken ##0 !watchSelectBit |=> modeState == 3'h2)
        else $error("stop mode not entered");
    chk_watch_entry: assert property (sStopTaken ##0 watchSelectBit |=> modeState == 3'h3)
        else $error("watch mode not entered");
    chk_stop_hold: assert property (modeState == 3'h2 |=> modeState == 3'h2)
        else $error("stop mode left without reset");
    chk_stop_float: assert property (modeState == 3'h2 |-> pinsFloat && !mainOscEn)
        else $error("stop mode outputs wrong");
    chk_nop_stays: assert property (modeState == 3'h0 && stopInstr && instrNop |=> modeState == 3'h0)
        else $error("cancelled stop changed mode");
    chk_active_clk: assert property (modeState == 3'h0 |-> cpuClockEn && mainOscEn && !subClockCpu)
        else $error("active mode clocks wrong");
    chk_standby_clk: assert property (modeState == 3'h1 |-> !cpuClockEn && mainOscEn && periphRun)
        else $error("standby clocks wrong");
    chk_sub_clk: assert property (modeState == 3'h5 |-> cpuClockEn && subClockCpu && !mainOscEn)
        else $error("subactive clocks wrong");
    chk_watch_clk: assert property (modeState == 3'h3 |-> !cpuClockEn && !periphRun)
        else $error("watch mode clocks wrong");
    chk_entry_gie: assert property (irqEntry |=> !irqRequest)
        else $error("request after interrupt entry");
    chk_req_mode: assert property (irqRequest |-> modeState == 3'h0 || modeState == 3'h5)
        else $error("request outside running mode");
endmodule : ipm_chk

bind ipm_irq_power_ctrl ipm_chk chkI (.clock(clock), .resetn(resetn), .stopInstr(stopInstr),
    .standbyInstr(standbyInstr), .irqEntry(irqEntry), .watchSelectBit(watchSelectBit),
    .instrNop(instrNop), .irqRequest(irqRequest), .cpuClockEn(cpuClockEn),
    .mainOscEn(mainOscEn), .subClockCpu(subClockCpu), .periphRun(periphRun),
    .pinsFloat(pinsFloat), .modeState(modeState));

/* File: ipm_src_model.sv */
// event source model: timer, a/d and serial pulses plus interrupt pin levels
`timescale 1ns/1ps
module ipm_src_model
(
    // clock, reset and command
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic       go,
    input  wire logic [3:0] code,
    // events toward the controller
    output logic [2:0]      pinLvl_q,
    output logic [5:0]      pulse_q
);
    logic [2:0] pinLvl_d;
    logic [5:0] pulse_d;

    // codes 0..2 toggle a pin, 3..8 give a one-cycle pulse
    always_comb
    begin
        pinLvl_d = pinLvl_q;
        pulse_d  = 6'h00;
        if (go && code < 4'h3)
            pinLvl_d[code[1:0]] = ~pinLvl_q[code[1:0]];
        else if (go)
            pulse_d[3'(code - 4'h3)] = 1'b1;
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            pinLvl_q <= 3'h1;
            pulse_q  <= 6'h00;
        end
        else
        begin
            pinLvl_q <= pinLvl_d;
            pulse_q  <= pulse_d;
        end
    end
endmodule : ipm_src_model

/* File: ipm_irq_power_ctrl_tb_top.sv */
// self-checking bench for the interrupt and power mode controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module ipm_irq_power_ctrl_tb_top
    import ipm_pkg::*;
;
    typedef struct packed {logic [9:0] a; logic [3:0] c, aft, unm, clr; logic [13:0] v;} ipm_row_t;
    logic clock, resetn, regWrite, regHit, irqRequest, instrNop, cpuClockEn, pinsFloat, go;
    logic wsb, lss, frameStrobe;
    logic adcRun, serialIrqEn, slowPeriphRun, periphResetReq;
    logic [3:0]  pmA, edgeSel;
    logic [9:0]  regAddr;
    logic [3:0]  regWdata, regRdata, code, instr;
    logic [13:0] irqVector;
    logic [2:0]  modeState, pins;
    logic [5:0]  pul;
    int          failures, nCompared, cycles;
    ipm_row_t    rows [8] = '{'{ADDR_WORD0, 4'h0, 4'hd, 4'h5, 4'h9, 14'h2},
        '{ADDR_WORD1, 4'h1, 4'hb, 4'h9, 4'ha, 14'h4}, '{ADDR_WORD1, 4'h3, 4'he, 4'h6, 4'ha, 14'h6},
        '{ADDR_WORD2, 4'h4, 4'hb, 4'h9, 4'ha, 14'h8}, '{ADDR_WORD2, 4'h5, 4'he, 4'h6, 4'ha, 14'ha},
        '{ADDR_WORD3, 4'h2, 4'hb, 4'h9, 4'ha, 14'hc}, '{ADDR_WORD3, 4'h6, 4'he, 4'h6, 4'ha, 14'he},
        '{ADDR_SERIAL, 4'h7, 4'hc, 4'h4, 4'h8, 14'he}};

    ipm_src_model srcI (.clock(clock), .resetn(resetn), .go(go), .code(code), .pinLvl_q(pins),
        .pulse_q(pul));
    ipm_irq_power_ctrl uut (.clock(clock), .resetn(resetn), .regAddr(regAddr),
        .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata), .regHit(regHit),
        .standbyInstr(instr[0]), .stopInstr(instr[1]), .irqEntry(instr[2]),
        .returnFromIrqInstr(instr[3]), .watchSelectBit(wsb), .lowSpeedSelect(lss),
        .extIrq0N(pins[0]), .extIrq1(pins[1]), .zeroCrossIn(pins[2]), .tmrAOverflow(pul[0]),
        .tmrBOverflow(pul[1]), .tmrCOverflow(pul[2]), .adcDone(pul[3]),
        .serialEighthClk(pul[4]), .serialCounterReset(pul[5]), .frameStrobe(frameStrobe),
        .irqRequest(irqRequest), .irqVector(irqVector), .instrNop(instrNop),
        .cpuClockEn(cpuClockEn), .mainOscEn(), .subClockCpu(), .periphRun(),
        .slowPeriphRun(slowPeriphRun), .adcRun(adcRun), .serialIrqEn(serialIrqEn),
        .periphResetReq(periphResetReq), .pinsFloat(pinsFloat), .portModeRegA(pmA),
        .irqEdgeSelectReg(edgeSel), .modeState(modeState));

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // ------------------------------------------------------------
    // bus, event and closing tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [9:0] a, input logic [3:0] d);
        @(posedge clock);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask : wr

    task automatic rd(input logic [9:0] a, input logic [3:0] e);
        @(posedge clock);
        regAddr <= a;
        @(negedge clock);
        `CHK("regRdata", e, regRdata)
    endtask : rd

    task automatic fire(input logic [3:0] c);
        @(posedge clock);
        code <= c;
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        repeat (3) @(negedge clock);
    endtask : fire

    task automatic pulse(input logic [3:0] v);
        @(posedge clock);
        instr <= v;
        @(posedge clock);
        instr <= 4'h0;
        @(negedge clock);
    endtask : pulse

    task automatic reset_dut();
        @(posedge clock);
        resetn <= 1'b0;
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
    endtask : reset_dut

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", nCompared, failures);
        if (failures == 0 && nCompared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {resetn, regWrite, go, wsb, lss, frameStrobe} = '0;
        {regAddr, regWdata, code, instr} = '0;
        {failures, nCompared, cycles} = '0;
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        rd(ADDR_WORD0, 4'h8);
        rd(ADDR_WORD2, 4'ha);
        rd(ADDR_EDGE, 4'h0);
        rd(10'h005, 4'h0);
        `CHK("regHit", 1'b0, regHit)
        $display("test reset done");
        wr(ADDR_WORD0, 4'h9);
        foreach (rows[i])
        begin
            fire(rows[i].c);
            fire(rows[i].c);
            rd(rows[i].a, rows[i].aft);
            `CHK("irqRequest", 1'b0, irqRequest)
            wr(rows[i].a, rows[i].unm);
            @(negedge clock);
            `CHK("irqRequest", 1'b1, irqRequest)
            `CHK("irqVector", rows[i].v, irqVector)
            wr(rows[i].a, rows[i].clr);
            rd(rows[i].a, rows[i].clr);
        end
        $display("test sources done");
        fire(4'h5);
        fire(4'h6);
        fire(4'h1);
        fire(4'h1);
        wr(ADDR_WORD1, 4'h9);
        wr(ADDR_WORD2, 4'h6);
        wr(ADDR_WORD3, 4'h6);
        @(negedge clock);
        `CHK("irqVector", 14'h4, irqVector)
        pulse(4'h4);
        `CHK("irqRequest", 1'b0, irqRequest)
        pulse(4'h8);
        `CHK("irqRequest", 1'b1, irqRequest)
        wr(ADDR_WORD1, 4'ha);
        wr(ADDR_WORD2, 4'ha);
        wr(ADDR_WORD3, 4'ha);
        fire(4'h8);
        rd(ADDR_SERIAL, 4'hc);
        wr(ADDR_SERIAL, 4'h8);
        wr(ADDR_EDGE, 4'h5);
        @(negedge clock);
        `CHK("irqEdgeSelectReg", 4'h5, edgeSel)
        fire(4'h1);
        rd(ADDR_WORD1, 4'hb);
        fire(4'h2);
        rd(ADDR_WORD3, 4'hb);
        wr(ADDR_WORD1, 4'ha);
        wr(ADDR_EDGE, 4'ha);
        fire(4'h1);
        rd(ADDR_WORD1, 4'hb);
        $display("test priority and edges done");
        wr(ADDR_WORD0, 4'h8);
        wr(ADDR_WORD1, 4'h2);
        wr(ADDR_WORD3, 4'ha);
        wr(ADDR_PMODEA, 4'h5);
        pulse(4'h1);
        `CHK("modeState", 3'h1, modeState)
        `CHK("cpuClockEn", 1'b0, cpuClockEn)
        fire(4'h3);
        rd(ADDR_WORD1, 4'h6);
        rd(ADDR_PMODEA, 4'h5);
        `CHK("portModeRegA", 4'h5, pmA)
        `CHK("modeState", 3'h0, modeState)
        `CHK("irqRequest", 1'b0, irqRequest)
        pulse(4'h2);
        `CHK("modeState", 3'h0, modeState)
        $display("test standby done");
        wr(ADDR_WORD1, 4'h2);
        wr(ADDR_WORD0, 4'h0);
        @(posedge clock);
        wsb <= 1'b1;
        pulse(4'h2);
        `CHK("modeState", 3'h3, modeState)
        `CHK("serialIrqEn", 1'b0, serialIrqEn)
        `CHK("adcRun", 1'b0, adcRun)
        `CHK("slowPeriphRun", 1'b1, slowPeriphRun)
        fire(4'h4);
        rd(ADDR_WORD2, 4'ha);
        @(posedge clock);
        lss <= 1'b1;
        fire(4'h3);
        `CHK("modeState", 3'h5, modeState)
        `CHK("adcRun", 1'b0, adcRun)
        wr(ADDR_WORD1, 4'h2);
        pulse(4'h1);
        `CHK("modeState", 3'h3, modeState)
        @(posedge clock);
        lss <= 1'b0;
        fire(4'h0);
        `CHK("modeState", 3'h4, modeState)
        $display("test watch done");
        reset_dut();
        @(posedge clock);
        wsb <= 1'b0;
        pulse(4'h2);
        `CHK("modeState", 3'h2, modeState)
        `CHK("pinsFloat", 1'b1, pinsFloat)
        `CHK("periphResetReq", 1'b1, periphResetReq)
        fire(4'h3);
        `CHK("modeState", 3'h2, modeState)
        reset_dut();
        @(negedge clock);
        `CHK("modeState", 3'h0, modeState)
        $display("test stop done");
        give_verdict();
    end
endmodule : ipm_irq_power_ctrl_tb_top
